/* File: core/blie_pkg.sv */
// shared constants for the bit and logic instruction executor
package blie_pkg;
    // instruction word shape
    localparam int BLIE_IW = 14;
    localparam int BLIE_DW = 8;
    localparam int BLIE_AW = 7;
    // field positions
    localparam int BLIE_DEST_POS = 7;
    localparam int BLIE_BIT_LSB = 7;
    localparam int BLIE_BIT_W = 3;
    // byte-oriented opcodes, word bits 13:8
    localparam logic [5:0] BLIE_OP_ADD_W_TO_FILE = 6'h07;
    localparam logic [5:0] BLIE_OP_AND_W_WITH_FILE = 6'h05;
    localparam logic [5:0] BLIE_OP_AND_LITERAL_WITH_W = 6'h39;
    // bit-oriented opcodes, word bits 13:10
    localparam logic [3:0] BLIE_OP_BIT_CLEAR_FILE = 4'h4;
    localparam logic [3:0] BLIE_OP_BIT_SET_FILE = 4'h5;
    localparam logic [3:0] BLIE_OP_BIT_TEST_SKIP_IF_CLEAR = 4'h6;
    localparam logic [3:0] BLIE_OP_BIT_TEST_SKIP_IF_SET = 4'h7;
    // reset values
    localparam logic [7:0] BLIE_W_RST = 8'h00;
    // flag write mask positions: zero, digit carry, carry
    localparam int BLIE_FLAG_Z = 2;
    localparam int BLIE_FLAG_DC = 1;
    localparam int BLIE_FLAG_C = 0;
    // execution slot state
    typedef enum logic {BLIE_EXEC, BLIE_FLUSH} blie_state_e;
endpackage : blie_pkg

/* File: core/blie_bit_sel.sv */
// one-hot mask and bit pick for bit-oriented instructions
`timescale 1ns/1ps
module blie_bit_sel #(
    parameter int DW = 8,
    parameter int SW = 3
) (
    input wire logic [DW-1:0] data,
    input wire logic [SW-1:0] sel,
    output logic [DW-1:0] mask,
    output logic bit_val
);
    // mask drives set and clear, bit_val drives the skip tests
    assign mask = DW'(1) << sel;
    assign bit_val = data[sel];
endmodule : blie_bit_sel

/* File: core/blie_exec.sv */
// executor for add, and, bit set/clear and bit-test-skip instructions
// Contract
// - skip-if-clear skips next when bit is 0
// - skipped prefetch discarded, no-operation runs instead
// - skip-if-clear: one cycle, two when skipping
// - skip-if-set skips next when bit is 1
// - skip-if-set timing; bit tests leave flags alone
// - skip-if-clear decoded with bit and address fields
// - skip-if-set differs only by prefix bits
`timescale 1ns/1ps
module blie_exec (
    clk_sys,
    rst_n,
    instr_valid,
    instr_word,
    file_rd_data,
    w_r,
    file_we_r,
    file_waddr_r,
    file_wdata_r,
    flag_we_r,
    flag_z_r,
    flag_dc_r,
    flag_c_r,
    skip_r,
    nop_slot_r,
    retire_r,
    foreign_r
);
    import blie_pkg::*;
    input wire logic clk_sys; // instruction cycle clock
    input wire logic rst_n; // synchronous, active low
    input wire logic instr_valid; // instr_word holds an instruction this cycle
    input wire logic [blie_pkg::BLIE_IW-1:0] instr_word; // fetched instruction
    input wire logic [blie_pkg::BLIE_DW-1:0] file_rd_data; // file register at instr_word[6:0]
    output logic [blie_pkg::BLIE_DW-1:0] w_r; // working register
    output logic file_we_r; // file write strobe
    output logic [blie_pkg::BLIE_AW-1:0] file_waddr_r; // file write address
    output logic [blie_pkg::BLIE_DW-1:0] file_wdata_r; // file write data
    output logic [2:0] flag_we_r; // which flags were updated (z, dc, c)
    output logic flag_z_r; // zero flag value
    output logic flag_dc_r; // digit carry value
    output logic flag_c_r; // carry value
    output logic skip_r; // prefetched word is being discarded
    output logic nop_slot_r; // a no-operation ran in the skipped slot
    output logic retire_r; // an instruction of this group completed
    output logic foreign_r; // word was not of this group, ignored

    blie_state_e state_r; // slot state
    blie_state_e state_nxt;

    // field extraction
    wire [5:0] op6 = instr_word[13:8];
    wire [3:0] op4 = instr_word[13:10];
    wire dest_file = instr_word[BLIE_DEST_POS];
    wire [BLIE_AW-1:0] faddr = instr_word[BLIE_AW-1:0];
    wire [BLIE_BIT_W-1:0] bsel = instr_word[BLIE_BIT_LSB +: BLIE_BIT_W];
    wire [BLIE_DW-1:0] lit = instr_word[BLIE_DW-1:0];

    // only words in an execute slot count; a flush slot ignores its word
    wire live = instr_valid && (state_r == BLIE_EXEC);
    wire is_add = live && (op6 == BLIE_OP_ADD_W_TO_FILE);
    wire is_andf = live && (op6 == BLIE_OP_AND_W_WITH_FILE);
    wire is_andl = live && (op6 == BLIE_OP_AND_LITERAL_WITH_W);
    wire is_bclr = live && (op4 == BLIE_OP_BIT_CLEAR_FILE);
    wire is_bset = live && (op4 == BLIE_OP_BIT_SET_FILE);
    wire is_tclr = live && (op4 == BLIE_OP_BIT_TEST_SKIP_IF_CLEAR);
    wire is_tset = live && (op4 == BLIE_OP_BIT_TEST_SKIP_IF_SET);
    wire is_ours = is_add || is_andf || is_andl || is_bclr || is_bset || is_tclr || is_tset;

    // bit mask and tested bit
    wire [BLIE_DW-1:0] bmask;
    wire bval;
    blie_bit_sel #(.DW(BLIE_DW), .SW(BLIE_BIT_W)) u_bit_sel (
        .data(file_rd_data),
        .sel(bsel),
        .mask(bmask),
        .bit_val(bval)
    );

    // arithmetic: low nibble sum gives the digit carry
    wire [4:0] low_sum = {1'b0, w_r[3:0]} + {1'b0, file_rd_data[3:0]};
    wire [8:0] full_sum = {1'b0, w_r} + {1'b0, file_rd_data};
    wire [BLIE_DW-1:0] and_f = w_r & file_rd_data;
    wire [BLIE_DW-1:0] and_l = w_r & lit;

    // skip when clear bit reads 0
    wire skip_clr = is_tclr && !bval;
    // skip when set bit reads 1
    wire skip_set = is_tset && bval;
    wire skip_go = skip_clr || skip_set;

    // result of the byte/bit op, chosen by opcode
    wire [BLIE_DW-1:0] result = is_add ? full_sum[BLIE_DW-1:0] :
                                is_andf ? and_f :
                                is_andl ? and_l :
                                is_bclr ? (file_rd_data & ~bmask) :
                                (file_rd_data | bmask);
    // destination: d=1 file, d=0 W; literal always to W
    wire to_file = ((is_add || is_andf) && dest_file) || is_bclr || is_bset;
    wire to_w = ((is_add || is_andf) && !dest_file) || is_andl;
    // flag update masks; bit ops and bit tests touch none
    wire z_upd = is_add || is_andf || is_andl;
    wire cdc_upd = is_add;

    // two slots only on a taken skip; same for skip-if-set
    always_comb begin
        state_nxt = BLIE_EXEC;
        unique case (state_r)
            BLIE_EXEC: if (skip_go) begin
                state_nxt = BLIE_FLUSH;
            end
            BLIE_FLUSH: state_nxt = BLIE_EXEC;
        endcase
    end

    // slot state; one flush slot at most
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= BLIE_EXEC;
        end else begin
            state_r <= state_nxt;
        end
    end

    // working register; only written by this group
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            w_r <= BLIE_W_RST;
        end else if (to_w) begin
            w_r <= result;
        end
    end

    // file write-back registered; strobe comes the cycle after the instruction
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            file_we_r <= 1'b0;
            file_waddr_r <= '0;
            file_wdata_r <= '0;
        end else begin
            file_we_r <= to_file;
            file_waddr_r <= faddr;
            file_wdata_r <= result;
        end
    end

    // flags: bit tests never raise a flag write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flag_we_r <= 3'h0;
            flag_z_r <= 1'b0;
            flag_dc_r <= 1'b0;
            flag_c_r <= 1'b0;
        end else begin
            flag_we_r <= {z_upd, cdc_upd, cdc_upd};
            flag_z_r <= z_upd ? (result == '0) : flag_z_r;
            flag_dc_r <= cdc_upd ? low_sum[4] : flag_dc_r;
            flag_c_r <= cdc_upd ? full_sum[8] : flag_c_r;
        end
    end

    // discard prefetch and run a no-operation in its slot
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            skip_r <= 1'b0;
            nop_slot_r <= 1'b0;
            retire_r <= 1'b0;
            foreign_r <= 1'b0;
        end else begin
            skip_r <= skip_go;
            nop_slot_r <= (state_r == BLIE_FLUSH);
            retire_r <= is_ours;
            foreign_r <= live && !is_ours;
        end
    end

    // checks: sequences for the skip steps
    sequence s_taken_clr;
        is_tclr && !bval;
    endsequence
    sequence s_taken_set;
        is_tset && bval;
    endsequence

    property p_clr_skip;
        @(posedge clk_sys) disable iff (!rst_n) s_taken_clr |=> skip_r && state_r == BLIE_FLUSH;
    endproperty
    a_clr_skip: assert property (p_clr_skip) else $error("clear test did not skip");

    property p_flush_nop;
        @(posedge clk_sys) disable iff (!rst_n)
            state_r == BLIE_FLUSH |=> nop_slot_r && !file_we_r && !retire_r && $stable(w_r);
    endproperty
    a_flush_nop: assert property (p_flush_nop) else $error("discarded word had an effect");

    property p_clr_time;
        @(posedge clk_sys) disable iff (!rst_n)
            s_taken_clr |=> state_r == BLIE_FLUSH ##1 state_r == BLIE_EXEC;
    endproperty
    a_clr_time: assert property (p_clr_time) else $error("taken clear test not two cycles");

    property p_set_skip;
        @(posedge clk_sys) disable iff (!rst_n) s_taken_set |=> skip_r ##1 nop_slot_r;
    endproperty
    a_set_skip: assert property (p_set_skip) else $error("set test did not skip");

    property p_test_flags;
        @(posedge clk_sys) disable iff (!rst_n)
            (is_tclr || is_tset) |=> flag_we_r == 3'h0 && $stable(flag_z_r) && $stable(flag_dc_r) &&
                $stable(flag_c_r);
    endproperty
    a_test_flags: assert property (p_test_flags) else $error("bit test touched flags");

    // raw word fields, not the decode wires
    property p_clr_decode;
        @(posedge clk_sys) disable iff (!rst_n)
            live && instr_word[13:10] == BLIE_OP_BIT_TEST_SKIP_IF_CLEAR |=>
                retire_r && !foreign_r && !file_we_r && flag_we_r == 3'h0 &&
                skip_r == !$past(file_rd_data[instr_word[BLIE_BIT_LSB +: BLIE_BIT_W]]);
    endproperty
    a_clr_decode: assert property (p_clr_decode) else $error("clear test misdecoded");

    property p_set_decode;
        @(posedge clk_sys) disable iff (!rst_n)
            is_tset && !bval |=> !skip_r && state_r == BLIE_EXEC;
    endproperty
    a_set_decode: assert property (p_set_decode) else $error("untaken set test stalled");

    property p_add_dest;
        @(posedge clk_sys) disable iff (!rst_n)
            is_add && !dest_file |=> w_r == 8'($past(w_r) + $past(file_rd_data)) && !file_we_r && retire_r;
    endproperty
    a_add_dest: assert property (p_add_dest) else $error("add to W went astray");
endmodule : blie_exec

/* File: sim/blie_file_model.sv */
// file register datapath model facing the executor
`timescale 1ns/1ps
module blie_file_model (
    input wire logic clk_sys,
    input wire logic [13:0] instr_word,
    input wire logic file_we_r,
    input wire logic [6:0] file_waddr_r,
    input wire logic [7:0] file_wdata_r,
    output logic [7:0] file_rd_data
);
    logic [7:0] mem [128]; // file registers, seeded from address
    // combinational read of the addressed register
    assign file_rd_data = mem[instr_word[6:0]];
    // write lands mid-cycle, so the next word already reads it
    always @(negedge clk_sys) begin
        if (file_we_r) begin
            mem[file_waddr_r] <= file_wdata_r;
        end
    end
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 37);
        end
    end
endmodule : blie_file_model

/* File: sim/bit_and_logic_instr_exec_tb.sv */
// self-checking bench for the bit and logic executor
`timescale 1ns/1ps
module bit_and_logic_instr_exec_tb;
    import blie_pkg::*;
    logic clk_sys = 0, rst_n = 0, instr_valid = 0;
    logic [13:0] instr_word = '0;
    logic [7:0] file_rd_data, w_r, file_wdata_r;
    logic [6:0] file_waddr_r;
    logic [2:0] flag_we_r;
    logic file_we_r, flag_z_r, flag_dc_r, flag_c_r, skip_r, nop_slot_r, retire_r, foreign_r;
    logic [33:0] notes [$]; // expected results, oldest first
    logic [33:0] exp_v;
    logic [7:0] fm [128]; // expected file contents
    logic [7:0] w_e; // expected working register
    logic [2:0] fl_e; // expected {z, dc, c}
    logic skip_pend; // next word is the discarded prefetch
    int num_errors = 0, cmp_count = 0, seed = 32'h2419;
    wire [33:0] obs = {retire_r, skip_r, nop_slot_r, foreign_r, file_we_r, flag_we_r,
        flag_z_r, flag_dc_r, flag_c_r, w_r, file_waddr_r, file_wdata_r};
    blie_exec DUT (.clk_sys, .rst_n, .instr_valid, .instr_word, .file_rd_data, .w_r, .file_we_r,
        .file_waddr_r, .file_wdata_r, .flag_we_r, .flag_z_r, .flag_dc_r, .flag_c_r, .skip_r,
        .nop_slot_r, .retire_r, .foreign_r);
    blie_file_model fmod (.clk_sys, .instr_word, .file_we_r, .file_waddr_r, .file_wdata_r, .file_rd_data);
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    // present one word and note what must come out one edge later
    task automatic step(input logic v, input logic [13:0] iw);
        logic [7:0] f, r, m;
        logic [8:0] s;
        logic [4:0] d;
        logic [33:0] n;
        logic wr;
        f = fm[iw[6:0]];
        m = 8'h01 << iw[9:7];
        s = {1'b0, w_e} + f;
        d = 5'(w_e[3:0]) + 5'(f[3:0]);
        n = '0;
        wr = 0;
        r = '0;
        instr_valid = v;
        instr_word = iw;
        if (skip_pend) begin
            n[31] = 1'b1;
            skip_pend = 0;
        end else if (v) begin
            n[33] = 1'b1;
            if (iw[13:8] == BLIE_OP_ADD_W_TO_FILE) begin
                r = s[7:0];
                fl_e = {r == 0, d[4], s[8]};
                n[28:26] = 3'b111;
                wr = iw[7];
            end else if (iw[13:8] == BLIE_OP_AND_W_WITH_FILE) begin
                r = w_e & f;
                wr = iw[7];
            end else if (iw[13:8] == BLIE_OP_AND_LITERAL_WITH_W) begin
                r = w_e & iw[7:0];
            end else if (iw[13:10] == BLIE_OP_BIT_CLEAR_FILE) begin
                r = f & ~m;
                wr = 1;
            end else if (iw[13:10] == BLIE_OP_BIT_SET_FILE) begin
                r = f | m;
                wr = 1;
            end else if (iw[13:10] == BLIE_OP_BIT_TEST_SKIP_IF_CLEAR) begin
                skip_pend = (f & m) == 0;
            end else if (iw[13:10] == BLIE_OP_BIT_TEST_SKIP_IF_SET) begin
                skip_pend = (f & m) != 0;
            end else begin
                n[33] = 0;
                n[30] = 1'b1;
            end
            if (iw[13:8] == BLIE_OP_AND_W_WITH_FILE || iw[13:8] == BLIE_OP_AND_LITERAL_WITH_W) begin
                fl_e[2] = r == 0;
                n[28] = 1'b1;
            end
            if (wr) begin
                fm[iw[6:0]] = r;
                n[29] = 1'b1;
                n[14:0] = {iw[6:0], r};
            end else if (n[33] && iw[13:12] == 2'b00 || iw[13:8] == BLIE_OP_AND_LITERAL_WITH_W) begin
                w_e = r;
            end
            n[32] = skip_pend;
        end
        n[25:15] = {fl_e, w_e};
        notes.push_back(n);
    endtask : step
    // scoreboard: each settled result against the oldest note
    always @(posedge clk_sys) begin
        #1;
        if (notes.size() > 0) begin
            exp_v = notes.pop_front();
            // address and data only matter with a write
            check(exp_v[29] ? obs : {obs[33:15], exp_v[14:0]}, exp_v);
        end
    end
    initial begin
        logic [31:0] k;
        logic [13:0] iw;
        skip_pend = 0;
        w_e = BLIE_W_RST;
        fl_e = '0;
        for (int i = 0; i < 128; i++) begin
            fm[i] = 8'(i * 37);
        end
        repeat (4) @(posedge clk_sys);
        #1 check(obs, '0);
        @(negedge clk_sys) rst_n = 1;
        // random mix of every opcode, foreign and idle words
        repeat (400) begin
            k = $random(seed);
            case (k[31:29])
                0: iw = {BLIE_OP_ADD_W_TO_FILE, k[7:0]};
                1: iw = {BLIE_OP_AND_W_WITH_FILE, k[7:0]};
                2: iw = {BLIE_OP_AND_LITERAL_WITH_W, k[7:0]};
                3: iw = {BLIE_OP_BIT_CLEAR_FILE, k[9:0]};
                4: iw = {BLIE_OP_BIT_SET_FILE, k[9:0]};
                5: iw = {BLIE_OP_BIT_TEST_SKIP_IF_CLEAR, k[9:0]};
                6: iw = {BLIE_OP_BIT_TEST_SKIP_IF_SET, k[9:0]};
                default: iw = {6'h00, k[7:0]};
            endcase
            step(skip_pend || k[12:10] != 0, iw);
            @(negedge clk_sys);
        end
        instr_valid = 0;
        repeat (2) @(posedge clk_sys);
        #2 give_verdict();
    end
    // watchdog well past the expected run length
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
endmodule : bit_and_logic_instr_exec_tb
